//--- ucfs_pkg.sv
// Constants and types shared by the serial frame control block.
// Assumes a 32-bit AHB-Lite slave port where each register takes one word.
`default_nettype none
package ucfs_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [11:0] IDX_DATA   = 12'h0f40;
  localparam logic [11:0] IDX_CTL0   = 12'h0f42;
  localparam logic [11:0] IDX_CTL1   = 12'h0f43;
  localparam logic [11:0] IDX_MPSTAT = 12'h0f44;
  localparam logic [11:0] IDX_BAUD   = 12'h0f48;
  localparam logic [11:0] IDX_ISTS   = 12'h0f49;
  localparam logic [11:0] IDX_IMASK  = 12'h0f4a;
  localparam logic [11:0] IDX_NONE   = 12'h0000;
  localparam logic [2:0]  HSIZE_WORD = 3'h2;
  // Primary control fields.
  localparam int C0_TEN  = 7;
  localparam int C0_REN  = 6;
  localparam int C0_CLEAR_TO_SEND_GATING = 5;
  localparam int C0_PEN  = 4;
  localparam int C0_PSEL = 3;
  localparam int C0_SEND_BREAK_BIT = 2;
  localparam int C0_STOP = 1;
  localparam int C0_LOOPBACK_ENABLE_BIT = 0;
  // Second control fields.
  localparam int C1_NINTH_BIT_MODE_ENABLE = 6;
  localparam int C1_MPBT = 4;
  // Multiprocessor status fields.
  localparam int MS_FIRST_BYTE_OF_FRAME_FLAG = 1;
  localparam int MS_RECEIVED_NINTH_BIT   = 0;
  // Interrupt status and mask fields.
  localparam int IRQ_W   = 5;
  localparam int IRQ_RX  = 0;
  localparam int IRQ_TX  = 1;
  localparam int IRQ_PAR = 2;
  localparam int IRQ_FRM = 3;
  localparam int IRQ_BRK = 4;
  // Reset values.
  localparam logic [7:0]  CTL_RST  = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h0001;
  // Oversampling: sixteen ticks per bit, sampled at the middle tick.
  localparam logic [3:0]  SUB_LAST = 4'hf;
  localparam logic [3:0]  SUB_MID  = 4'h7;
  localparam logic [3:0]  TX_BITS  = 4'ha;
  typedef struct packed {
    logic nine_en;
    logic par_en;
    logic par_odd;
    logic two_stop;
    logic nine_tx;
  } ucfs_frame_t;
endpackage
`default_nettype wire

//--- ucfs_tx.sv
// Serial character transmitter, least significant bit first.
// Assumes a one-cycle oversampling tick at sixteen times the bit rate.
`default_nettype none
module ucfs_tx
  import ucfs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        tick,
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic [7:0]  data,
  input  wire ucfs_frame_t cfg,
  output var  logic        busy,
  output var  logic        ser
);
  logic [11:0] shift_reg;
  logic [3:0]  cnt_reg;
  logic [3:0]  sub_reg;
  logic        extra;
  logic        extra_bit;
  assign extra     = cfg.nine_en | cfg.par_en;
  assign extra_bit = cfg.nine_en ? cfg.nine_tx : (^data ^ cfg.par_odd);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 12'h0fff;
      cnt_reg   <= 4'h0;
      sub_reg   <= 4'h0;
      busy      <= 1'b0;
    end else if (abort) begin
      busy      <= 1'b0;
      shift_reg <= 12'h0fff;
    end else if (start && !busy) begin
      // Frame length counts start, data, optional ninth bit and stops.
      shift_reg <= {2'b11, extra ? extra_bit : 1'b1, data, 1'b0};
      cnt_reg   <= TX_BITS + {3'h0, extra} + {3'h0, cfg.two_stop};
      sub_reg   <= 4'h0;
      busy      <= 1'b1;
    end else if (busy && tick) begin
      sub_reg <= sub_reg + 4'h1;
      if (sub_reg == SUB_LAST) begin
        shift_reg <= {1'b1, shift_reg[11:1]};
        cnt_reg   <= cnt_reg - 4'h1;
        busy      <= (cnt_reg != 4'h1);
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser <= 1'b1;
    end else begin
      ser <= busy ? shift_reg[0] : 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- ucfs_rx.sv
// Serial character receiver with mid-bit sampling and one stop bit checked.
// Assumes a synchronised serial input and a sixteen-times oversampling tick.
`default_nettype none
module ucfs_rx
  import ucfs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        tick,
  input  wire logic        en,
  input  wire logic        rxi,
  input  wire ucfs_frame_t cfg,
  output var  logic        done,
  output var  logic [7:0]  data,
  output var  logic        extra_bit,
  output var  logic        perr,
  output var  logic        ferr,
  output var  logic        brk
);
  logic [8:0] sh_reg;
  logic [3:0] idx_reg;
  logic [3:0] sub_reg;
  logic       act_reg;
  logic       extra;
  logic [3:0] last;
  assign extra = cfg.nine_en | cfg.par_en;
  assign last  = 4'h9 + {3'h0, extra};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_reg <= 9'h000;
      idx_reg <= 4'h0;
      sub_reg <= 4'h0;
      act_reg <= 1'b0;
      done <= 1'b0;
      data <= 8'h00;
      extra_bit <= 1'b0;
      perr <= 1'b0;
      ferr <= 1'b0;
      brk <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!en) begin
        act_reg <= 1'b0;
      end else if (!act_reg) begin
        act_reg <= !rxi;
        sub_reg <= 4'h0;
        idx_reg <= 4'h0;
      end else if (tick) begin
        sub_reg <= sub_reg + 4'h1;
        if (sub_reg == SUB_MID) begin
          idx_reg <= idx_reg + 4'h1;
          if (idx_reg == 4'h0) begin
            act_reg <= !rxi;
          end else if (idx_reg == last) begin
            act_reg   <= 1'b0;
            done      <= 1'b1;
            data      <= sh_reg[7:0];
            extra_bit <= extra & sh_reg[8];
            perr      <= cfg.par_en && ((^sh_reg) != cfg.par_odd);
            ferr      <= !rxi;
            brk       <= !rxi && (sh_reg == 9'h000);
          end else begin
            sh_reg[idx_reg - 4'h1] <= rxi;
          end
        end
      end
      if (!act_reg && en && !rxi) begin
        sh_reg <= 9'h000;
      end
    end
  end
endmodule
`default_nettype wire

//--- ucfs_top.sv
// Serial port frame control and multiprocessor status behind an AHB-Lite slave.
// Assumes one bus master, word transfers, and asynchronous rxd and cts_n pins.
//
// Functional notes
// - First-data-byte flag sets on a frame's first data byte, clears on data read.
// - Status bit zero shows last ninth bit received, cleared on data read.
// - Control bit seven enables the transmitter.
// - With gating bit set, a character starts only while CTS is low.
// - Control bit six enables the receiver.
// - Parity enable adds a parity bit on transmit and receive.
// - Nine-bit mode overrides the parity enable.
// - Bit three selects even parity at zero, odd parity at one.
// - Send-break forces the transmit output low, cutting any character.
// - Releasing break adds no stop bit or idle time.
// - Control bit one selects one or two stop bits.
// - Loopback bit routes transmitted data into the receiver.
// - Second control bit six enables nine-bit multiprocessor characters.
`default_nettype none
module ucfs_top
  import ucfs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  input  wire logic        rxd,
  input  wire logic        cts_n,
  output var  logic        txd,
  output var  logic        irq
);
  logic [7:0]       ctl0_reg;
  logic [7:0]       ctl1_reg;
  logic [15:0]      baud_reg;
  logic [15:0]      bcnt_reg;
  logic             tick_reg;
  logic [7:0]       txbuf_reg;
  logic             txfull_reg;
  logic [7:0]       rxbuf_reg;
  logic             first_byte_of_frame_flag_reg;
  logic             received_ninth_bit_reg;
  logic             lastaddr_reg;
  logic [IRQ_W-1:0] ists_reg;
  logic [IRQ_W-1:0] imask_reg;
  logic             wr_pend_reg;
  logic             rd_pend_reg;
  logic [11:0]      idx_reg;
  logic             rxd_s1;
  logic             rxd_s2;
  logic             cts_s1;
  logic             cts_s2;
  logic             txbusy_dly_reg;
  logic             acc;
  logic             map_ok;
  logic             data_rd;
  logic             tx_go;
  logic             tx_start;
  logic             tx_busy;
  logic             tx_ser;
  logic             rx_in;
  logic             rx_done;
  logic [7:0]       rx_data;
  logic             rx_extra;
  logic             rx_perr;
  logic             rx_ferr;
  logic             rx_brk;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] w1c;
  logic [31:0]      rd_mux;
  ucfs_frame_t      cfg;

  // Pin synchronisers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      cts_s1 <= 1'b1;
      cts_s2 <= 1'b1;
    end else begin
      rxd_s1 <= rxd;
      rxd_s2 <= rxd_s1;
      cts_s1 <= cts_n;
      cts_s2 <= cts_s1;
    end
  end

  // Bus address phase capture; reads take one wait state.
  assign acc    = hsel && htrans[1] && hready;
  assign map_ok = (haddr[31:14] == 18'h00000) && (haddr[1:0] == 2'b00);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      idx_reg     <= IDX_NONE;
      hreadyout   <= 1'b1;
    end else begin
      wr_pend_reg <= acc && hwrite && (hsize == HSIZE_WORD);
      rd_pend_reg <= acc && !hwrite;
      hreadyout   <= !(acc && !hwrite);
      if (acc) begin
        idx_reg <= map_ok ? haddr[13:2] : IDX_NONE;
      end
    end
  end

  // Every transfer is answered OKAY; the slave never signals an error.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Read multiplexer; unmapped indices read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (idx_reg)
      IDX_DATA:   rd_mux[7:0] = rxbuf_reg;
      IDX_CTL0:   rd_mux[7:0] = ctl0_reg;
      IDX_CTL1:   rd_mux[7:0] = ctl1_reg;
      IDX_MPSTAT: rd_mux[1:0] = {first_byte_of_frame_flag_reg, received_ninth_bit_reg};
      IDX_BAUD:   rd_mux[15:0] = baud_reg;
      IDX_ISTS:   rd_mux[IRQ_W-1:0] = ists_reg;
      IDX_IMASK:  rd_mux[IRQ_W-1:0] = imask_reg;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      hrdata <= rd_mux;
    end
  end

  assign data_rd = rd_pend_reg && (idx_reg == IDX_DATA);

  // Control registers; software keeps them still while the port runs.
  // Nothing blocks a write while enabled, so such a change applies at once.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl0_reg <= CTL_RST;
      ctl1_reg <= CTL_RST;
      baud_reg <= BAUD_RST;
    end else if (wr_pend_reg) begin
      if (idx_reg == IDX_CTL0) begin
        ctl0_reg <= hwdata[7:0];
      end
      if (idx_reg == IDX_CTL1) begin
        ctl1_reg <= hwdata[7:0];
      end
      if (idx_reg == IDX_BAUD) begin
        baud_reg <= hwdata[15:0];
      end
    end
  end

  // Frame format as seen by both shifters.
  always_comb begin
    cfg.nine_en  = ctl1_reg[C1_NINTH_BIT_MODE_ENABLE];
    cfg.par_en   = ctl0_reg[C0_PEN] && !ctl1_reg[C1_NINTH_BIT_MODE_ENABLE];
    cfg.par_odd  = ctl0_reg[C0_PSEL];
    cfg.two_stop = ctl0_reg[C0_STOP];
    cfg.nine_tx  = ctl1_reg[C1_MPBT];
  end

  // Oversampling tick every divisor cycles; a divisor of zero acts as one.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bcnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if ((bcnt_reg + 16'h0001) >= baud_reg) begin
      bcnt_reg <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      bcnt_reg <= bcnt_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  // Transmit holding byte.
  // A second write before the shifter takes the first byte overwrites it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txbuf_reg  <= 8'h00;
      txfull_reg <= 1'b0;
    end else if (wr_pend_reg && (idx_reg == IDX_DATA)) begin
      txbuf_reg  <= hwdata[7:0];
      txfull_reg <= 1'b1;
    end else if (tx_start) begin
      txfull_reg <= 1'b0;
    end
  end

  // CTS gates only the start of a character; one already under way finishes.
  // Enable and CTS gating
  assign tx_go    = ctl0_reg[C0_TEN] && (!ctl0_reg[C0_CLEAR_TO_SEND_GATING] || !cts_s2);
  assign tx_start = tx_go && txfull_reg && !tx_busy;

  ucfs_tx u_tx (
    .clk   (hclk),
    .rst_n (hresetn),
    .tick  (tick_reg),
    .start (tx_start),
    .abort (!ctl0_reg[C0_TEN]),
    .data  (txbuf_reg),
    .cfg   (cfg),
    .busy  (tx_busy),
    .ser   (tx_ser)
  );

  // The shifter keeps running under a break, so software waits for idle first.
  // Break forces low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd <= 1'b1;
    end else begin
      txd <= ctl0_reg[C0_SEND_BREAK_BIT] ? 1'b0 : tx_ser;
    end
  end

  assign rx_in = ctl0_reg[C0_LOOPBACK_ENABLE_BIT] ? txd : rxd_s2;

  // Only the first stop bit is checked, so two-stop frames are received too.
  ucfs_rx u_rx (
    .clk       (hclk),
    .rst_n     (hresetn),
    .tick      (tick_reg),
    .en        (ctl0_reg[C0_REN]),
    .rxi       (rx_in),
    .cfg       (cfg),
    .done      (rx_done),
    .data      (rx_data),
    .extra_bit (rx_extra),
    .perr      (rx_perr),
    .ferr      (rx_ferr),
    .brk       (rx_brk)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxbuf_reg <= 8'h00;
    end else if (rx_done) begin
      rxbuf_reg <= rx_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      received_ninth_bit_reg <= 1'b0;
    end else if (rx_done) begin
      received_ninth_bit_reg <= cfg.nine_en && rx_extra;
    end else if (data_rd) begin
      received_ninth_bit_reg <= 1'b0;
    end
  end

  // The flag depends on the previous ninth bit, so that bit is remembered.
  // First data byte flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_byte_of_frame_flag_reg   <= 1'b0;
      lastaddr_reg <= 1'b0;
    end else if (rx_done && cfg.nine_en) begin
      first_byte_of_frame_flag_reg   <= !rx_extra && lastaddr_reg;
      lastaddr_reg <= rx_extra;
    end else if (data_rd) begin
      first_byte_of_frame_flag_reg <= 1'b0;
    end
  end

  // Interrupt events, sticky status with write-one-to-clear and mask.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txbusy_dly_reg <= 1'b0;
    end else begin
      txbusy_dly_reg <= tx_busy;
    end
  end

  always_comb begin
    ev = '0;
    ev[IRQ_RX]  = rx_done;
    ev[IRQ_TX]  = txbusy_dly_reg && !tx_busy;
    ev[IRQ_PAR] = rx_done && rx_perr;
    ev[IRQ_FRM] = rx_done && rx_ferr;
    ev[IRQ_BRK] = rx_done && rx_brk;
  end

  assign w1c = (wr_pend_reg && (idx_reg == IDX_ISTS)) ? hwdata[IRQ_W-1:0] : '0;

  for (genvar i = 0; i < IRQ_W; i++) begin : g_ists
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ists_reg[i] <= 1'b0;
      end else if (ev[i]) begin
        ists_reg[i] <= 1'b1;
      end else if (w1c[i]) begin
        ists_reg[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      imask_reg <= '0;
    end else if (wr_pend_reg && (idx_reg == IDX_IMASK)) begin
      imask_reg <= hwdata[IRQ_W-1:0];
    end
  end

  // The output is taken from the next status value, so it rises with the bit
  // and falls in the same cycle as a write-one-to-clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((ists_reg | ev) & ~(w1c & ~ev) & imask_reg);
    end
  end
endmodule
`default_nettype wire

//--- ucfs_properties.sv
// Concurrent checks on the ports of the serial frame control block.
// Assumes one bus master, word transfers and the reset baud divisor.
`default_nettype none
module ucfs_properties
  import ucfs_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        cts_n,
  input wire logic        txd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        wr_q;
  logic        rd_q;
  logic [11:0] idx_q;
  logic [7:0]  ctl_q;
  logic [7:0]  off_cnt;
  logic [7:0]  cts_cnt;
  logic [7:0]  idle_cnt;
  wire         take = hsel && htrans[1] && hready;
  function automatic logic [7:0] sat(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h1;
  endfunction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      idx_q <= IDX_NONE;
    end else if (hready) begin
      wr_q  <= take && hwrite && (hsize == HSIZE_WORD);
      rd_q  <= take && !hwrite;
      idx_q <= haddr[13:2];
    end
  end
  // Shadow of the primary control register, taken from bus writes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_q <= CTL_RST;
    end else if (wr_q && hready && idx_q == IDX_CTL0) begin
      ctl_q <= hwdata[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      off_cnt  <= 8'h0;
      cts_cnt  <= 8'h0;
      idle_cnt <= 8'h0;
    end else begin
      off_cnt  <= (ctl_q[C0_TEN] || ctl_q[C0_SEND_BREAK_BIT]) ? 8'h0 : sat(off_cnt);
      cts_cnt  <= cts_n ? sat(cts_cnt) : 8'h0;
      idle_cnt <= txd ? sat(idle_cnt) : 8'h0;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_write_no_wait: assert property (take && hwrite |=> hreadyout && !hresp)
    else $error("write data phase was stalled");
  chk_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout && !hresp)
    else $error("read did not take exactly one wait state");
  chk_hrdata_stands: assert property ($changed(hrdata) |-> rd_q && hreadyout)
    else $error("read data changed outside a read");
  chk_ctl_readback: assert property (
    rd_q && hreadyout && idx_q == IDX_CTL0 |-> hrdata == {24'h0, ctl_q})
    else $error("control read differs from the last write");
  chk_status_upper: assert property (
    rd_q && hreadyout && idx_q == IDX_MPSTAT |-> hrdata[31:2] == 30'h0)
    else $error("reserved status bits read nonzero");
  chk_break_low: assert property (
    ctl_q[C0_SEND_BREAK_BIT] && $past(ctl_q[C0_SEND_BREAK_BIT]) |-> !txd)
    else $error("line not held low during break");
  chk_tx_off_idle: assert property (off_cnt >= 8'h3 |-> txd)
    else $error("line not idle with transmitter off");
  // The idle count saturating means no character is under way.
  chk_cts_gate: assert property (
    ctl_q[C0_TEN] && ctl_q[C0_CLEAR_TO_SEND_GATING] && !ctl_q[C0_SEND_BREAK_BIT] && cts_cnt >= 8'h5
    && idle_cnt == 8'hff |=> txd)
    else $error("character started while clear to send was high");
endmodule
bind ucfs_top ucfs_properties chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
  .hready, .hreadyout, .hresp, .hrdata, .cts_n, .txd
);
`default_nettype wire

//--- ucfs_remote.sv
// Remote station on the serial line: sends nine-bit characters, reads txd.
// Assumes sixteen clocks per bit; tasks are entered just after a rising edge.
`default_nettype none
module ucfs_remote (
  input  wire logic clk,
  input  wire logic txd,
  output var  logic rxd,
  output var  logic cts_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_CLKS = 16;
  initial begin
    rxd   = 1'b1;
    cts_n = 1'b0;
  end
  task automatic set_cts(input logic v);
    cts_n <= v;
  endtask
  // The line returns high after the stop bit, as its pull-up would leave it.
  task automatic send(input logic [7:0] d, input logic b9);
    logic [10:0] f;
    f = {1'b1, b9, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
  endtask
  // Returns at the middle of the last bit, each bit sampled mid-cell.
  task automatic recv(input int nb, output logic [11:0] f);
    int w;
    f = 12'h0;
    w = 0;
    while (txd !== 1'b0 && w < 4000) begin
      @(posedge clk);
      w++;
    end
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      f[i] = txd;
      if (i < nb - 1) repeat (BIT_CLKS) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

//--- uart_frame_control_status_tb.sv
// Self-checking bench for the serial frame control block.
// Assumes the reset baud divisor, so each bit lasts sixteen clocks.
`default_nettype none
`define ck(n, e, g) begin checks_done++; if ((g) !== (e)) mismatch(n, e, g); end
module uart_frame_control_status_tb
  import ucfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] dat;
    logic       b9;
    logic [7:0] ists;
    logic [7:0] ms;
  } ucfs_row_t;
  localparam ucfs_row_t ROWS [6] = '{
    '{8'h80, 8'h0, 8'h5a, 1'b0, 8'h2, 8'h0},
    '{8'h82, 8'h0, 8'ha5, 1'b0, 8'h2, 8'h0},
    '{8'hd1, 8'h0, 8'h3c, 1'b0, 8'h3, 8'h0},
    '{8'hd9, 8'h0, 8'h0f, 1'b1, 8'h3, 8'h0},
    '{8'hd1, 8'h50, 8'h81, 1'b1, 8'h3, 8'h1},
    '{8'hd3, 8'h40, 8'h55, 1'b0, 8'h3, 8'h2}
  };
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = HSIZE_WORD;
  logic [31:0] hwdata  = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        rxd;
  logic        cts_n;
  logic        txd;
  logic        irq;
  int          n_errors    = 0;
  int          checks_done = 0;
  always #12.5 hclk = ~hclk;
  ucfs_top uut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rxd, .cts_n, .txd, .irq
  );
  ucfs_remote remote (.clk(hclk), .txd, .rxd, .cts_n);
  task automatic mismatch(input string n, input logic [31:0] e, input logic [31:0] g);
    $display("unexpected %s: expected %h, seen %h", n, e, g);
    n_errors++;
  endtask
  task automatic test_done;
    $display("checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wait_ready;
    int w;
    w = 0;
    do begin
      @(posedge hclk);
      w++;
    end while (hreadyout !== 1'b1 && w < 20);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      test_done();
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                     input logic [2:0] sz, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= sz;
    haddr  <= {18'h0, idx, 2'h0};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [31:0] v;
    bus(1'b1, idx, {24'h0, d}, HSIZE_WORD, v);
  endtask
  task automatic rchk(input string n, input logic [11:0] idx, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, idx, 32'h0, HSIZE_WORD, v);
    `ck(n, e, v)
  endtask
  task automatic wait_irq(input logic v);
    int w;
    w = 0;
    while (irq !== v && w < 16) begin
      @(posedge hclk);
      w++;
    end
    `ck("irq", {31'h0, v}, {31'h0, irq})
  endtask
  initial begin : main
    logic [31:0] v;
    logic [11:0] f;
    logic [11:0] e;
    logic        h9;
    ucfs_row_t   r;
    int          nb;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk("ctl0 reset", IDX_CTL0, 32'h0);
    rchk("mpstat reset", IDX_MPSTAT, 32'h0);
    rchk("unmapped", IDX_NONE, 32'h0);
    bus(1'b1, IDX_NONE, 32'h8, HSIZE_WORD, v);
    rchk("unmapped write", IDX_NONE, 32'h0);
    wr(IDX_MPSTAT, 8'h0);
    wr(IDX_IMASK, 8'h2);
    remote.set_cts(1'b1);
    foreach (ROWS[i]) begin
      r = ROWS[i];
      wr(IDX_CTL0, 8'h0);
      wr(IDX_CTL1, r.ctl1);
      wr(IDX_CTL0, r.ctl0);
      wr(IDX_DATA, r.dat);
      h9 = r.ctl0[C0_PEN] | r.ctl1[C1_NINTH_BIT_MODE_ENABLE];
      nb = 10 + int'(h9) + int'(r.ctl0[C0_STOP]);
      e = h9 ? {2'b11, r.b9, r.dat, 1'b0} : {3'b111, r.dat, 1'b0};
      e = e & ~(12'hfff << nb);
      remote.recv(nb, f);
      `ck("frame", {20'h0, e}, {20'h0, f})
      `ck("irq early", 32'h0, {31'h0, irq})
      wait_irq(1'b1);
      rchk("status", IDX_ISTS, {24'h0, r.ists});
      if (r.ctl0[C0_LOOPBACK_ENABLE_BIT]) begin
        if (r.ctl1[C1_NINTH_BIT_MODE_ENABLE]) rchk("mpstat", IDX_MPSTAT, {24'h0, r.ms});
        rchk("rx data", IDX_DATA, {24'h0, r.dat});
        rchk("mpstat clear", IDX_MPSTAT, 32'h0);
      end
      wr(IDX_ISTS, 8'h1f);
      wait_irq(1'b0);
    end
    wr(IDX_CTL0, 8'h0);
    wr(IDX_CTL1, 8'h0);
    wr(IDX_CTL0, 8'ha0);
    wr(IDX_DATA, 8'hc3);
    nb = 0;
    repeat (300) begin
      @(posedge hclk);
      if (txd !== 1'b1) nb++;
    end
    `ck("held low bits", 32'h0, 32'(nb))
    remote.set_cts(1'b0);
    remote.recv(10, f);
    `ck("gated frame", 32'h386, {20'h0, f})
    wait_irq(1'b1);
    wr(IDX_ISTS, 8'h1f);
    wr(IDX_CTL0, 8'h0);
    wr(IDX_CTL0, 8'h45);
    repeat (3) @(posedge hclk);
    `ck("break", 32'h0, {31'h0, txd})
    repeat (200) @(posedge hclk);
    wr(IDX_CTL0, 8'h0);
    repeat (2) @(posedge hclk);
    `ck("break release", 32'h1, {31'h0, txd})
    rchk("break status", IDX_ISTS, 32'h19);
    wr(IDX_ISTS, 8'h1f);
    wr(IDX_CTL0, 8'h50);
    remote.send(8'h01, 1'b0);
    rchk("parity status", IDX_ISTS, 32'h5);
    wr(IDX_ISTS, 8'h1f);
    wr(IDX_CTL0, 8'h0);
    wr(IDX_CTL1, 8'h40);
    wr(IDX_CTL0, 8'h40);
    remote.send(8'h96, 1'b1);
    `ck("masked irq", 32'h0, {31'h0, irq})
    rchk("mpstat addr", IDX_MPSTAT, 32'h1);
    rchk("rx addr", IDX_DATA, 32'h96);
    remote.send(8'h21, 1'b0);
    rchk("mpstat data", IDX_MPSTAT, 32'h2);
    rchk("rx status", IDX_ISTS, 32'h1);
    wr(IDX_IMASK, 8'h1);
    wait_irq(1'b1);
    wr(IDX_ISTS, 8'h1);
    wait_irq(1'b0);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk("ctl0 after reset", IDX_CTL0, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
